// file: design/cns_pkg.sv
// package: constants for the can node sequencer
package cns_pkg;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int CLK_NS        = 20;
  localparam int SPI_HALF_NS   = 5000;
  localparam int SPI_HALF_CYC  = SPI_HALF_NS / CLK_NS;
  localparam int TICK_BASE_NS  = 1000;
  localparam int TICK_BASE_CYC = TICK_BASE_NS / CLK_NS;
  localparam int TICK_PRESCALE = 256;
  localparam int TICK_COUNTS   = 38;
  localparam logic [7:0] TICK_RELOAD = 8'(TICK_PRESCALE - TICK_COUNTS);
  localparam logic [7:0] TICK_TOP    = 8'hFF;
  localparam int ADC_DIV       = 8;
  localparam int ADC_HALF_BITS = 19;
  localparam int ADC_CONV_CYC  = (ADC_DIV * ADC_HALF_BITS + 1) / 2;
  localparam int CONFIRM_US    = 2000;
  localparam int CONFIRM_CYC   = CONFIRM_US * 1000 / CLK_NS;
  // ****************************************************
  // controller commands, addresses and values
  // ****************************************************
  localparam logic [7:0] SPI_WRITE   = 8'h02;
  localparam logic [7:0] SPI_READ    = 8'h03;
  localparam logic [7:0] SPI_BITMOD  = 8'h05;
  localparam logic [7:0] SPI_RTS0    = 8'h81;
  localparam logic [7:0] A_CANCTRL   = 8'h0F;
  localparam logic [7:0] A_CNF3      = 8'h28;
  localparam logic [7:0] A_CNF2      = 8'h29;
  localparam logic [7:0] A_CNF1      = 8'h2A;
  localparam logic [7:0] A_IRQ_EN    = 8'h2B;
  localparam logic [7:0] A_IRQ_FLAGS = 8'h2C;
  localparam logic [7:0] A_ERR_FLAGS = 8'h2D;
  localparam logic [7:0] A_IN_PINS   = 8'h0D;
  localparam logic [7:0] A_OUT_PINS  = 8'h0C;
  localparam logic [7:0] A_TXB0CTRL  = 8'h30;
  localparam logic [7:0] A_TXB0SIDH  = 8'h31;
  localparam logic [7:0] A_RX2CTRL   = 8'h70;
  localparam logic [7:0] A_RX2D0     = 8'h76;
  localparam logic [7:0] A_RXM0H     = 8'h20;
  localparam logic [7:0] A_RXM0L     = 8'h21;
  localparam logic [7:0] A_RXM1H     = 8'h24;
  localparam logic [7:0] A_RXM1L     = 8'h25;
  localparam logic [7:0] A_RXF [6]   = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h18};
  localparam logic [7:0] MODE_CONFIG = 8'h80;
  localparam logic [7:0] MODE_NORMAL = 8'h00;
  localparam logic [7:0] CNF1_VAL    = 8'h03;  // sjw 1 tq, prescaler divide-by-4
  localparam logic [7:0] CNF2_VAL    = 8'h90;  // prop 1 tq, phase one 3 tq
  localparam logic [7:0] CNF3_VAL    = 8'h02;  // phase two 3 tq
  localparam logic [7:0] IRQ_EN_VAL  = 8'h22;  // error and second buffer only
  localparam logic [7:0] IN_PINS_VAL = 8'h00;  // mode bits cleared
  localparam logic [7:0] OUT_PINS_VAL = 8'h0C; // enables set, selects cleared
  localparam logic [7:0] MASK_H      = 8'hFF;
  localparam logic [7:0] MASK_L      = 8'hE0;
  localparam logic [7:0] OUT1_SEL    = 8'h10;
  localparam logic [7:0] OUT2_SEL    = 8'h20;
  localparam logic [7:0] DLC_ONE     = 8'h01;
  localparam logic [4:0] INIT_LEN    = 5'h18;
  localparam logic [4:0] INIT_FILT0  = 5'h0B;
  // ****************************************************
  // bit positions, filters, identifiers, codes
  // ****************************************************
  localparam int IF_RX2 = 1;
  localparam int IF_ERR = 5;
  localparam logic [7:0] IF_HANDLED = 8'h22;
  localparam int EF_RX2OVR = 7;
  localparam int EF_TXBO   = 5;
  localparam int EF_TXEP   = 4;
  localparam int EF_RXEP   = 3;
  localparam int EF_RXWAR  = 1;
  localparam int EF_EWARN  = 0;
  localparam int TX_REQ    = 3;
  localparam int IN_LSB    = 3;
  localparam logic [2:0] FH_ANALOG = 3'h2;
  localparam logic [2:0] FH_INPUTS = 3'h3;
  localparam logic [2:0] FH_OUT1   = 3'h4;
  localparam logic [2:0] FH_OUT2   = 3'h5;
  localparam logic [10:0] ID_UNUSED   = 11'h000;
  localparam logic [10:0] ID_REQ_BASE = 11'h3F0;
  localparam logic [10:0] ID_REPLY    = 11'h008;
  localparam logic [10:0] ID_PERIODIC = 11'h3FE;
  localparam logic [10:0] ID_ERROR    = 11'h3FF;
  localparam logic [7:0] CODE_RX2OVR = 8'h11;
  localparam logic [7:0] CODE_RXWARN = 8'h02;
  localparam logic [7:0] CODE_WARN   = 8'h01;
  localparam logic [7:0] CODE_RXEP   = 8'h03;
  localparam logic [7:0] CODE_TXEP   = 8'h04;
  localparam logic [7:0] CODE_BUSOFF = 8'h12;
  localparam logic [7:0] INVALID_MESSAGE_CODE = 8'h20;
  localparam int TX_LEN = 8;
endpackage : cns_pkg

// file: design/cns_sequencer.sv
// can node sequencer: controller setup, tick sampling, request and error service
`timescale 1ns/10ps
`default_nettype none
module cns_sequencer #(
  parameter int TICK_BASE_CYCLES = cns_pkg::TICK_BASE_CYC,
  parameter int CONFIRM_CYCLES   = cns_pkg::CONFIRM_CYC,
  parameter int SPI_HALF_CYCLES  = cns_pkg::SPI_HALF_CYC
) (
  input  wire logic       clock_i,
  input  wire logic       nrst_i,
  input  wire logic       irq_input_pin_n_i,
  output logic            spi_cs_n_o,
  output logic            spi_sck_o,
  input  wire logic       shared_serial_data_pin_i,
  output logic            shared_serial_data_pin_o,
  output logic            shared_serial_data_pin_oe_o,
  input  wire logic       conversion_done_flag_i,
  input  wire logic [7:0] conversion_result_i,
  output logic            adc_start_o,
  output logic            adc_channel_o,
  output logic            adc_clk_o,
  output logic            bus_off_flag_o,
  output logic            halted_o,
  output logic            busy_o
);
  import cns_pkg::*;

  typedef enum logic [19:0] {
    ST_INIT = 20'h00001, ST_IDLE = 20'h00002, ST_ADC = 20'h00004, ST_ADC_WAIT = 20'h00008,
    ST_SEND = 20'h00010, ST_RTS = 20'h00020, ST_TICK_END = 20'h00040, ST_DISPATCH = 20'h00080,
    ST_FILT = 20'h00100, ST_PINS = 20'h00200, ST_OUTSET = 20'h00400, ST_ERRCHK = 20'h00800,
    ST_ERR = 20'h01000, ST_BO_SEND = 20'h02000, ST_CONFIRM = 20'h04000, ST_CHECK = 20'h08000,
    ST_INVCHK = 20'h10000, ST_CLEAR = 20'h20000, ST_HALT = 20'h40000, ST_SPI = 20'h80000
  } cns_state_t;
  typedef enum logic [5:0] {
    SP_IDLE = 6'h01, SP_LEAD = 6'h02, SP_LOW = 6'h04, SP_HIGH = 6'h08, SP_TRAIL = 6'h10, SP_GAP = 6'h20
  } cns_spi_t;

  function automatic logic [15:0] init_entry(input logic [4:0] idx);
    logic [2:0]  f;
    logic [10:0] fid;
    f   = 3'((idx - INIT_FILT0) >> 1);
    fid = (f < FH_ANALOG) ? ID_UNUSED : ID_REQ_BASE + 11'(f - FH_ANALOG);
    case (idx)
      5'h00:   init_entry = {A_CANCTRL, MODE_CONFIG};
      5'h01:   init_entry = {A_CNF1, CNF1_VAL};
      5'h02:   init_entry = {A_CNF2, CNF2_VAL};
      5'h03:   init_entry = {A_CNF3, CNF3_VAL};
      5'h04:   init_entry = {A_IRQ_EN, IRQ_EN_VAL};
      5'h05:   init_entry = {A_IN_PINS, IN_PINS_VAL};
      5'h06:   init_entry = {A_OUT_PINS, OUT_PINS_VAL};
      5'h07:   init_entry = {A_RXM0H, MASK_H};
      5'h08:   init_entry = {A_RXM0L, MASK_L};
      5'h09:   init_entry = {A_RXM1H, MASK_H};
      5'h0A:   init_entry = {A_RXM1L, MASK_L};
      5'h17:   init_entry = {A_CANCTRL, MODE_NORMAL};
      default: init_entry = idx[0] ? {A_RXF[f], fid[10:3]} : {A_RXF[f] + DLC_ONE, fid[2:0], 5'h00};
    endcase
  endfunction : init_entry

  // ****************************************************
  // input synchronisers
  // ****************************************************
  logic       irq_meta, irq_sync, irq_prev, sdi_meta, sdi_sync, done_meta, done_sync;
  logic [7:0] res_meta, res_sync;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      {irq_meta, irq_sync, irq_prev} <= 3'h7;
      {sdi_meta, sdi_sync, done_meta, done_sync} <= 4'h0;
      res_meta <= 8'h00;
      res_sync <= 8'h00;
    end else begin
      {irq_meta, irq_sync, irq_prev} <= {irq_input_pin_n_i, irq_meta, irq_sync};
      {sdi_meta, sdi_sync} <= {shared_serial_data_pin_i, sdi_meta};
      {done_meta, done_sync} <= {conversion_done_flag_i, done_meta};
      res_meta <= conversion_result_i;
      res_sync <= res_meta;
    end
  end
  wire irq_fall = irq_prev & ~irq_sync;

  // ****************************************************
  // tick counter and converter clock
  // ****************************************************
  cns_state_t st, ret, send_ret, init_ret;
  logic [15:0] base_cnt;
  logic [7:0]  prescale, tick_counter;
  logic        tick_pending, ext_pending;
  logic [2:0]  adc_div;
  wire base_end  = base_cnt == 16'(TICK_BASE_CYCLES - 1);
  wire pre_end   = base_end && prescale == TICK_TOP;
  wire tick_wrap = pre_end && tick_counter == TICK_TOP;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      base_cnt <= 16'h0000;
      prescale <= 8'h00;
      tick_counter <= TICK_RELOAD;
      tick_pending <= 1'b0;
      ext_pending <= 1'b0;
      adc_div <= 3'h0;
      adc_clk_o <= 1'b0;
    end else begin
      base_cnt <= base_end ? 16'h0000 : base_cnt + 16'h0001;
      prescale <= base_end ? prescale + 8'h01 : prescale;
      if (st == ST_TICK_END) tick_counter <= TICK_RELOAD;
      else if (pre_end) tick_counter <= tick_counter + 8'h01;
      if (tick_wrap) tick_pending <= 1'b1;
      else if (st == ST_TICK_END) tick_pending <= 1'b0;
      if (irq_fall) ext_pending <= 1'b1;
      else if (st == ST_CLEAR) ext_pending <= 1'b0;
      adc_div <= adc_div + 3'h1;
      adc_clk_o <= adc_div[2];
    end
  end

  // ****************************************************
  // three-wire spi engine
  // ****************************************************
  cns_spi_t   sp_st;
  logic [7:0] txb [TX_LEN];
  logic [7:0] sp_tmr, spi_rx;
  logic [6:0] bitpos;
  logic [3:0] nwr;
  logic       rd, spi_go, spi_done, sck, cs_n, sdo, sdo_oe;
  wire [3:0] nbytes   = nwr + {3'h0, rd};
  wire       sp_half  = sp_tmr == 8'(SPI_HALF_CYCLES - 1);
  wire [7:0] cur_byte = txb[bitpos[5:3]];
  wire       cur_bit  = cur_byte[~bitpos[2:0]];
  wire       in_read  = bitpos[6:3] >= nwr;
  wire       last_bit = bitpos[6:3] == nbytes - 4'h1 && bitpos[2:0] == 3'h7;
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sp_st <= SP_IDLE;
      sp_tmr <= 8'h00;
      spi_rx <= 8'h00;
      bitpos <= 7'h00;
      {spi_done, sck, sdo} <= 3'h0;
      {cs_n, sdo_oe} <= 2'h3;
    end else begin
      spi_done <= 1'b0;
      sp_tmr <= sp_half ? 8'h00 : sp_tmr + 8'h01;
      case (sp_st)
        SP_IDLE: begin
          sp_tmr <= 8'h00;
          if (spi_go) begin
            cs_n <= 1'b0;
            bitpos <= 7'h00;
            sp_st <= SP_LEAD;
          end
        end
        SP_LEAD: if (sp_half) sp_st <= SP_LOW;
        SP_LOW: begin
          if (sp_tmr == 8'h00) begin
            sdo <= cur_bit;
            sdo_oe <= ~in_read;
          end
          if (sp_half) begin
            sck <= 1'b1;
            sp_st <= SP_HIGH;
          end
        end
        SP_HIGH: if (sp_half) begin
          sck <= 1'b0;
          spi_rx <= {spi_rx[6:0], sdi_sync};
          if (last_bit) sp_st <= SP_TRAIL;
          else begin
            bitpos <= bitpos + 7'h01;
            sp_st <= SP_LOW;
          end
        end
        SP_TRAIL: if (sp_half) begin
          cs_n <= 1'b1;
          sdo <= 1'b0;
          sdo_oe <= 1'b1;
          sp_st <= SP_GAP;
        end
        SP_GAP: if (sp_half) begin
          spi_done <= 1'b1;
          sp_st <= SP_IDLE;
        end
        default: sp_st <= SP_IDLE;
      endcase
    end
  end

  // ****************************************************
  // service sequencer
  // ****************************************************
  logic [4:0]  init_idx;
  logic [7:0]  intf, tx_data, out_sel;
  logic [10:0] tx_id;
  logic [23:0] wait_cnt;
  logic        adc_ch, adc_start, bus_off;
  wire [15:0] init_word = init_entry(init_idx);
  wire [10:0] reply_id  = ID_REQ_BASE | ID_REPLY | 11'(spi_rx[2:0] - FH_ANALOG);
  always_ff @(posedge clock_i or negedge nrst_i) begin
    if (!nrst_i) begin
      st <= ST_INIT;
      {ret, send_ret, init_ret} <= {ST_IDLE, ST_IDLE, ST_IDLE};
      init_idx <= 5'h00;
      for (int i = 0; i < TX_LEN; i++) txb[i] <= 8'h00;
      {intf, tx_data, out_sel} <= 24'h000000;
      tx_id <= ID_UNUSED;
      wait_cnt <= 24'h000000;
      nwr <= 4'h0;
      {rd, spi_go, adc_ch, adc_start, bus_off} <= 5'h00;
    end else begin
      spi_go <= 1'b0;
      adc_start <= 1'b0;
      wait_cnt <= wait_cnt + 24'h000001;
      case (st)
        ST_INIT: if (init_idx == INIT_LEN) st <= init_ret;
        else begin
          {txb[0], txb[1], txb[2]} <= {SPI_WRITE, init_word};
          {nwr, rd, spi_go, ret, st} <= {4'h3, 1'b0, 1'b1, ST_INIT, ST_SPI};
          init_idx <= init_idx + 5'h01;
        end
        ST_IDLE: if (tick_pending) begin
          {adc_ch, tx_id, send_ret, st} <= {1'b0, ID_PERIODIC, ST_TICK_END, ST_ADC};
        end else if (ext_pending) begin
          {txb[0], txb[1]} <= {SPI_READ, A_IRQ_FLAGS};
          {nwr, rd, spi_go, ret, st} <= {4'h2, 1'b1, 1'b1, ST_DISPATCH, ST_SPI};
        end
        ST_ADC: {adc_start, wait_cnt, st} <= {1'b1, 24'h000000, ST_ADC_WAIT};
        // a fresh start may not yet show the busy flag after synchronising
        ST_ADC_WAIT: if (wait_cnt >= 24'(ADC_CONV_CYC) && !done_sync) begin
          tx_data <= res_sync;
          st <= ST_SEND;
        end
        ST_SEND: begin
          {txb[0], txb[1], txb[2], txb[3]} <= {SPI_WRITE, A_TXB0SIDH, tx_id[10:3], tx_id[2:0], 5'h00};
          {txb[4], txb[5], txb[6], txb[7]} <= {8'h00, 8'h00, DLC_ONE, tx_data};
          {nwr, rd, spi_go, ret, st} <= {4'h8, 1'b0, 1'b1, ST_RTS, ST_SPI};
        end
        ST_RTS: begin
          txb[0] <= SPI_RTS0;
          {nwr, rd, spi_go, ret, st} <= {4'h1, 1'b0, 1'b1, send_ret, ST_SPI};
        end
        ST_TICK_END: st <= ST_IDLE;
        ST_DISPATCH: begin
          intf <= spi_rx;
          {txb[0], txb[1]} <= {SPI_READ, A_RX2CTRL};
          if (spi_rx[IF_RX2]) {nwr, rd, spi_go, ret, st} <= {4'h2, 1'b1, 1'b1, ST_FILT, ST_SPI};
          else st <= ST_ERRCHK;
        end
        ST_FILT: begin
          {tx_id, send_ret} <= {reply_id, ST_ERRCHK};
          if (spi_rx[2:0] == FH_ANALOG) {adc_ch, st} <= {1'b1, ST_ADC};
          else if (spi_rx[2:0] == FH_INPUTS) begin
            {txb[0], txb[1]} <= {SPI_READ, A_IN_PINS};
            {nwr, rd, spi_go, ret, st} <= {4'h2, 1'b1, 1'b1, ST_PINS, ST_SPI};
          end else if (spi_rx[2:0] == FH_OUT1 || spi_rx[2:0] == FH_OUT2) begin
            out_sel <= (spi_rx[2:0] == FH_OUT2) ? OUT2_SEL : OUT1_SEL;
            {txb[0], txb[1]} <= {SPI_READ, A_RX2D0};
            {nwr, rd, spi_go, ret, st} <= {4'h2, 1'b1, 1'b1, ST_OUTSET, ST_SPI};
          end else {tx_id, tx_data, st} <= {ID_ERROR, INVALID_MESSAGE_CODE, ST_SEND};
        end
        ST_PINS: {tx_data, st} <= {5'h00, spi_rx[IN_LSB +: 3], ST_SEND};
        ST_OUTSET: begin
          {txb[0], txb[1], txb[2]} <= {SPI_BITMOD, A_OUT_PINS, out_sel};
          txb[3] <= (spi_rx != 8'h00) ? out_sel : 8'h00;
          {nwr, rd, spi_go, ret, st} <= {4'h4, 1'b0, 1'b1, ST_ERRCHK, ST_SPI};
        end
        ST_ERRCHK: if (intf[IF_ERR]) begin
          {txb[0], txb[1]} <= {SPI_READ, A_ERR_FLAGS};
          {nwr, rd, spi_go, ret, st} <= {4'h2, 1'b1, 1'b1, ST_ERR, ST_SPI};
        end else st <= ST_INVCHK;
        ST_ERR: begin
          {tx_id, send_ret, st} <= {ID_ERROR, ST_INVCHK, ST_SEND};
          if (spi_rx[EF_RX2OVR]) tx_data <= CODE_RX2OVR;
          else if (spi_rx[EF_EWARN]) tx_data <= spi_rx[EF_RXWAR] ? CODE_RXWARN : CODE_WARN;
          else if (spi_rx[EF_RXEP]) tx_data <= CODE_RXEP;
          else if (spi_rx[EF_TXEP]) tx_data <= CODE_TXEP;
          else if (spi_rx[EF_TXBO] && !bus_off) {init_idx, init_ret, st} <= {5'h00, ST_BO_SEND, ST_INIT};
          else if (spi_rx[EF_TXBO]) st <= ST_HALT;
          else st <= ST_INVCHK;
        end
        ST_BO_SEND: {tx_id, tx_data, send_ret, st} <= {ID_ERROR, CODE_BUSOFF, ST_CONFIRM, ST_SEND};
        ST_CONFIRM: if (ret != ST_CHECK) {wait_cnt, ret} <= {24'h000000, ST_CHECK};
        else if (wait_cnt == 24'(CONFIRM_CYCLES - 1)) begin
          {txb[0], txb[1]} <= {SPI_READ, A_TXB0CTRL};
          {nwr, rd, spi_go, st} <= {4'h2, 1'b1, 1'b1, ST_SPI};
        end
        ST_CHECK: if (!spi_rx[TX_REQ]) {bus_off, st} <= {1'b1, ST_INVCHK};
        else st <= ST_HALT;
        ST_INVCHK: if ((intf & ~IF_HANDLED) != 8'h00) begin
          {tx_id, tx_data, send_ret, st} <= {ID_ERROR, INVALID_MESSAGE_CODE, ST_CLEAR, ST_SEND};
        end else st <= ST_CLEAR;
        ST_CLEAR: begin
          {txb[0], txb[1], txb[2], txb[3]} <= {SPI_BITMOD, A_IRQ_FLAGS, intf, 8'h00};
          {nwr, rd, spi_go, ret, st} <= {4'h4, 1'b0, 1'b1, ST_IDLE, ST_SPI};
        end
        ST_HALT: st <= ST_HALT;
        ST_SPI: if (spi_done) st <= ret;
        default: st <= ST_HALT;
      endcase
    end
  end

  assign spi_cs_n_o                  = cs_n;
  assign spi_sck_o                   = sck;
  assign shared_serial_data_pin_o    = sdo;
  assign shared_serial_data_pin_oe_o = sdo_oe;
  assign adc_start_o                 = adc_start;
  assign adc_channel_o               = adc_ch;
  assign bus_off_flag_o              = bus_off;
  assign halted_o                    = st == ST_HALT;
  assign busy_o                      = st != ST_IDLE;
endmodule : cns_sequencer
`default_nettype wire

// file: test/cns_sequencer_asserts.sv
// checker: port timing relations of the can node sequencer
`timescale 1ns/10ps
`default_nettype none
module cns_sequencer_asserts #(parameter int TICK_BASE_CYCLES = 1, parameter int CONFIRM_CYCLES = 1) (
  input wire logic clock_i,
  input wire logic nrst_i,
  input wire logic irq_input_pin_n_i,
  input wire logic spi_cs_n_o,
  input wire logic spi_sck_o,
  input wire logic shared_serial_data_pin_oe_o,
  input wire logic adc_start_o,
  input wire logic adc_channel_o,
  input wire logic adc_clk_o,
  input wire logic bus_off_flag_o,
  input wire logic halted_o,
  input wire logic busy_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  a_sck_in_frame: assert property (spi_sck_o |-> !spi_cs_n_o)
    else $error("spi clock high outside a frame");
  a_release_in_frame: assert property (!shared_serial_data_pin_oe_o |-> !spi_cs_n_o)
    else $error("data pin released outside a frame");
  a_conv_clk_div: assert property ($rose(adc_clk_o) |=> (!$rose(adc_clk_o)) [*7] ##1 $rose(adc_clk_o))
    else $error("converter clock not one eighth");
  a_start_when_busy: assert property (adc_start_o |-> busy_o && spi_cs_n_o)
    else $error("conversion start outside service");
  a_chan_hold: assert property (adc_start_o |=> (!adc_start_o && $stable(adc_channel_o)) [*8])
    else $error("channel moved during conversion");
  a_halt_sticky: assert property (halted_o |=> halted_o && busy_o && spi_cs_n_o)
    else $error("halt left before reset");
  a_busoff_sticky: assert property (bus_off_flag_o |=> bus_off_flag_o)
    else $error("bus-off flag cleared");
  a_irq_wakes: assert property ($fell(irq_input_pin_n_i) && !busy_o |-> ##[1:8] busy_o)
    else $error("falling interrupt line not serviced");
endmodule : cns_sequencer_asserts
bind cns_sequencer cns_sequencer_asserts #(.TICK_BASE_CYCLES(TICK_BASE_CYCLES),
  .CONFIRM_CYCLES(CONFIRM_CYCLES)) u_chk (.*);
`default_nettype wire

// file: test/cns_ctrl_model.sv
// controller model: register file, spi command decode and transmit log
`timescale 1ns/10ps
`default_nettype none
module cns_ctrl_model (
  input  wire logic cs_n_i,
  input  wire logic sck_i,
  input  wire logic sdi_i,
  output logic      sdo_o
);
  logic [7:0]  r [256];
  logic [7:0]  cmd, adr, sh, msk;
  logic        lastb;
  logic [18:0] txq [$];
  int          nb = 0, nf = 0;
  initial foreach (r[i]) r[i] = 8'h00;
  // released line shows the inverse of a registered bit: no stale copy, no zero-delay loop
  assign sdo_o = (cmd == 8'h03 && nf >= 16) ? r[adr][7 - nf % 8] : ~lastb;
  always @(posedge sck_i) if (!cs_n_i) begin
    sh = {sh[6:0], sdi_i};
    lastb = sdi_i;
    nb = nb + 1;
    if (nb == 8) cmd = sh;
    if (nb == 8 && sh == 8'h81) txq.push_back({r[8'h31], r[8'h32][7:5], r[8'h36]});
    if (nb == 16) adr = sh;
    if (nb > 16 && nb % 8 == 0 && cmd == 8'h02) r[8'(adr + nb / 8 - 3)] = sh;
    if (nb == 24 && cmd == 8'h05) msk = sh;
    if (nb == 32 && cmd == 8'h05) r[adr] = (r[adr] & ~msk) | (sh & msk);
  end
  always @(negedge sck_i) if (!cs_n_i) nf = nf + 1;
  always @(posedge cs_n_i) begin
    nb = 0;
    nf = 0;
  end
endmodule : cns_ctrl_model
`default_nettype wire

// file: test/testbench.sv
// bench: sequencer against a controller model, converter stub and interrupt pulses
`timescale 1ns/10ps
`default_nettype none
module testbench;
  logic        clock_i = 0, nrst_i = 0, irq_n = 1, done = 0;
  logic [7:0]  res = 8'h00, cres = 8'h00, lf = 8'h04;
  logic [7:0]  ev [5] = '{8'h99, 8'h03, 8'h01, 8'h18, 8'h10};
  logic [7:0]  cd [5] = '{8'h11, 8'h02, 8'h01, 8'h03, 8'h04};
  logic [18:0] exq [$];
  wire         cs_n, sck, sdo, oe, start, ch, bo, halt, busy, mdl, line;
  int          err_count = 0, num_checks = 0, dcnt = 0, nt = 0;
  always #10 clock_i = ~clock_i;
  assign line = oe ? sdo : mdl;
  always @(posedge clock_i) begin
    dcnt <= start ? 80 : (dcnt > 0 ? dcnt - 1 : 0);
    done <= start || dcnt > 1;
    // requested channel reads back inverted, so a wrong channel shows in the reply
    cres <= ch ? ~res : res;
  end
  cns_sequencer #(.TICK_BASE_CYCLES(1), .CONFIRM_CYCLES(2000), .SPI_HALF_CYCLES(4)) dut (.clock_i(clock_i),
    .nrst_i(nrst_i), .irq_input_pin_n_i(irq_n), .spi_cs_n_o(cs_n), .spi_sck_o(sck), .shared_serial_data_pin_i(line),
    .shared_serial_data_pin_o(sdo), .shared_serial_data_pin_oe_o(oe), .conversion_done_flag_i(done),
    .conversion_result_i(cres), .adc_start_o(start), .adc_channel_o(ch), .adc_clk_o(), .bus_off_flag_o(bo),
    .halted_o(halt), .busy_o(busy));
  cns_ctrl_model m (.cs_n_i(cs_n), .sck_i(sck), .sdi_i(line), .sdo_o(mdl));
  function automatic logic [7:0] nx(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction : nx
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %0t: got %h want %h", $time, s, e);
    end
  endtask : chk
  task automatic idle();
    int n;
    n = 0;
    // three quiet cycles: a pending tick may follow the end of a service at once
    for (int k = 0; k < 600000 && n < 3; k++) begin
      @(negedge clock_i);
      n = busy === 1'b0 ? n + 1 : 0;
    end
    chk(n, 3);
  endtask : idle
  task automatic drain();
    logic [18:0] f;
    while (m.txq.size() > 0) begin
      f = m.txq.pop_front();
      if (f[18:8] === 11'h3FE) begin
        nt++;
        chk(f[7:0], res);
      end else
        chk(f, exq.size() > 0 ? exq.pop_front() : 19'h0);
    end
    chk(exq.size(), 0);
  endtask : drain
  task automatic svc(input logic [7:0] fl, input logic [7:0] ef, input logic [2:0] fh);
    m.r[8'h2C] = fl;
    m.r[8'h2D] = ef;
    m.r[8'h70] = {5'h00, fh};
    m.r[8'h76] = lf & 8'h01;
    m.r[8'h0D] = lf;
    @(posedge clock_i);
    irq_n <= 1'b0;
    repeat (4) @(posedge clock_i);
    irq_n <= 1'b1;
  endtask : svc
  task automatic final_report();
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : final_report
  initial begin
    lf = nx(lf);
    repeat (16) @(posedge clock_i);
    nrst_i <= 1'b1;
    res <= lf;
    idle();
    chk({m.r[8'h2A], m.r[8'h29], m.r[8'h28], m.r[8'h0F]}, 32'h03900200);
    chk({m.r[8'h2B], m.r[8'h0D], m.r[8'h0C]}, 24'h22000C);
    chk({m.r[8'h20], m.r[8'h24]}, 16'hFFFF);
    for (int fh = 2; fh < 7; fh++) begin
      lf = nx(lf);
      @(posedge clock_i);
      res <= lf;
      if (fh == 2) exq.push_back({11'h3F8, ~lf});
      if (fh == 3) exq.push_back({11'h3F9, 5'h00, lf[5:3]});
      if (fh == 6) exq.push_back({11'h3FF, 8'h20});
      if (fh == 6) exq.push_back({11'h3FF, 8'h20});
      svc(fh == 6 ? 8'h03 : 8'h02, 8'h00, 3'(fh));
      idle();
      drain();
      if (fh == 4 || fh == 5) chk({m.r[8'h0C][3:2], m.r[8'h0C][fh]}, {2'b11, lf[0]});
      chk(m.r[8'h2C], 8'h00);
    end
    for (int i = 0; i < 5; i++) begin
      exq.push_back({11'h3FF, cd[i]});
      svc(8'h20, ev[i], 3'h0);
      idle();
      drain();
    end
    exq.push_back({11'h3FF, 8'h12});
    svc(8'h20, 8'h20, 3'h0);
    idle();
    drain();
    chk({bo, halt, m.r[8'h0D]}, {2'b10, 8'h00});
    svc(8'h20, 8'h20, 3'h0);
    for (int k = 0; k < 200000 && halt !== 1'b1; k++) @(posedge clock_i);
    chk(halt, 1'b1);
    // fresh start, then a bus-off whose message stays pending
    nrst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    nrst_i <= 1'b1;
    idle();
    m.r[8'h30] = 8'h08;
    exq.push_back({11'h3FF, 8'h12});
    svc(8'h20, 8'h20, 3'h0);
    for (int k = 0; k < 200000 && halt !== 1'b1; k++) @(posedge clock_i);
    drain();
    chk({bo, halt}, 2'b01);
    chk(nt > 0, 1'b1);
    final_report();
  end
  initial begin
    #1_600_000;
    err_count++;
    final_report();
  end
endmodule : testbench
`default_nettype wire
